// [verilog/ddsc_pkg.sv]
// Purpose: Shared constants for the dual converter serial command port.
// Assumes: Command codes are six bits wide and code words ten bits wide.
// Notes:   Range encodings are the low three command bits of a range command.
package ddsc_pkg;

    // ****************************************************************
    // Widths and fixed values
    // ****************************************************************
    localparam int          CMD_W          = 6;
    localparam int          CODE_W         = 10;
    localparam int          RANGE_W        = 3;
    localparam int          FRAME_BITS     = 16;
    localparam int          BUS_FRAME_BITS = 27;
    localparam int          UPDATE_PULSE   = 26;
    localparam logic [4:0]  ADDR_FIXED     = 5'h0C;
    localparam logic [2:0]  RANGE_DEFAULT  = 3'h0;
    localparam logic [9:0]  CODE_RESET     = 10'h000;
    localparam logic        REF_EXTERNAL   = 1'b0;

    // ****************************************************************
    // Command codes
    // ****************************************************************
    localparam logic [5:0]  CMD_NOP        = 6'h00;
    localparam logic [5:0]  CMD_LOAD_AB    = 6'h01;
    localparam logic [5:0]  CMD_LOAD_A     = 6'h02;
    localparam logic [5:0]  CMD_LOAD_B     = 6'h03;
    localparam logic [5:0]  CMD_IN_AB      = 6'h04;
    localparam logic [5:0]  CMD_IN_A       = 6'h05;
    localparam logic [5:0]  CMD_IN_B       = 6'h06;
    localparam logic [5:0]  CMD_UPD_AB     = 6'h07;
    localparam logic [5:0]  CMD_UPD_A      = 6'h09;
    localparam logic [5:0]  CMD_UPD_B      = 6'h0A;
    localparam logic [5:0]  CMD_REF_INT    = 6'h0B;
    localparam logic [5:0]  CMD_REF_EXT    = 6'h0C;
    localparam logic [5:0]  CMD_SHDN_AB    = 6'h0D;
    localparam logic [5:0]  CMD_SHDN_A     = 6'h0E;
    localparam logic [5:0]  CMD_SHDN_B     = 6'h0F;
    localparam logic [5:0]  CMD_PWUP_AB    = 6'h2D;
    localparam logic [5:0]  CMD_PWUP_A     = 6'h2E;
    localparam logic [5:0]  CMD_PWUP_B     = 6'h2F;
    localparam logic [2:0]  RANGE_GRP_A    = 3'h2;
    localparam logic [2:0]  RANGE_GRP_B    = 3'h6;
    localparam logic [2:0]  RANGE_MAX      = 3'h5;

    typedef enum logic [2:0] {
        BUS_IDLE,
        BUS_RECV,
        BUS_ACK,
        BUS_IGNORE
    } ddsc_bus_state_t;

endpackage

// [verilog/ddsc_cmd_exec.sv]
// Purpose: Decodes one command and holds the converter control registers.
// Assumes: exec_pulse is a one-cycle strobe on mclk with cmd and code stable.
// Notes:   Unknown codes change nothing.
module ddsc_cmd_exec
    import ddsc_pkg::*;
(
    input  wire logic                mclk,
    input  wire logic                rst,
    input  wire logic                exec_pulse,
    input  wire logic [CMD_W-1:0]    cmd,
    input  wire logic [CODE_W-1:0]   code,
    output logic      [CODE_W-1:0]   out_code_a,
    output logic      [CODE_W-1:0]   out_code_b,
    output logic                     shdn_a,
    output logic                     shdn_b,
    output logic      [RANGE_W-1:0]  range_a,
    output logic      [RANGE_W-1:0]  range_b,
    output logic                     ref_internal
);

    logic [CODE_W-1:0] in_a_reg;
    logic [CODE_W-1:0] in_b_reg;

    wire ld_a   = (cmd == CMD_LOAD_AB) || (cmd == CMD_LOAD_A);
    wire ld_b   = (cmd == CMD_LOAD_AB) || (cmd == CMD_LOAD_B);
    wire in_a   = ld_a || (cmd == CMD_IN_AB) || (cmd == CMD_IN_A);
    wire in_b   = ld_b || (cmd == CMD_IN_AB) || (cmd == CMD_IN_B);
    wire upd_a  = (cmd == CMD_UPD_AB) || (cmd == CMD_UPD_A);
    wire upd_b  = (cmd == CMD_UPD_AB) || (cmd == CMD_UPD_B);
    wire sd_a   = (cmd == CMD_SHDN_AB) || (cmd == CMD_SHDN_A);
    wire sd_b   = (cmd == CMD_SHDN_AB) || (cmd == CMD_SHDN_B);
    wire pu_a   = (cmd == CMD_PWUP_AB) || (cmd == CMD_PWUP_A);
    wire pu_b   = (cmd == CMD_PWUP_AB) || (cmd == CMD_PWUP_B);
    wire rng_ok = (cmd[2:0] <= RANGE_MAX);
    wire rg_a   = (cmd[5:3] == RANGE_GRP_A) && rng_ok;
    wire rg_b   = (cmd[5:3] == RANGE_GRP_B) && rng_ok;

    // ****************************************************************
    // Register updates
    // ****************************************************************
    // Writes land even while a channel is shut down. RULE_12
    always_ff @(posedge mclk) begin
        if (rst) begin
            in_a_reg     <= CODE_RESET;
            in_b_reg     <= CODE_RESET;
            out_code_a   <= CODE_RESET;
            out_code_b   <= CODE_RESET;
            shdn_a       <= 1'b0;
            shdn_b       <= 1'b0;
            range_a      <= RANGE_DEFAULT; // RULE_13
            range_b      <= RANGE_DEFAULT; // RULE_13
            ref_internal <= REF_EXTERNAL; // RULE_13
        end else if (exec_pulse) begin
            if (in_a) in_a_reg <= code; // RULE_18
            if (in_b) in_b_reg <= code; // RULE_18
            if (ld_a) out_code_a <= code; // RULE_17
            else if (upd_a) out_code_a <= in_a_reg; // RULE_19
            if (ld_b) out_code_b <= code; // RULE_17
            else if (upd_b) out_code_b <= in_b_reg; // RULE_19
            if (cmd == CMD_REF_INT) ref_internal <= 1'b1; // RULE_20
            if (cmd == CMD_REF_EXT) ref_internal <= 1'b0; // RULE_20
            if (sd_a) shdn_a <= 1'b1; // RULE_21
            else if (pu_a) shdn_a <= 1'b0; // RULE_21
            if (sd_b) shdn_b <= 1'b1; // RULE_21
            else if (pu_b) shdn_b <= 1'b0; // RULE_21
            if (rg_a) range_a <= cmd[2:0]; // RULE_22
            if (rg_b) range_b <= cmd[2:0]; // RULE_22
        end
    end

endmodule

// [verilog/ddsc_top.sv]
// Purpose: Two-wire and three-wire command front end of a dual converter.
// Assumes: Bus pins are asynchronous; mclk is much faster than either bus clock.
// Notes:   Power-up defaults are modelled by the synchronous reset rst.
//
// Overview of operation
// RULE_01: Receiver pulls data low through ninth pulse.
// RULE_02: Address is 01100 plus two strap bits.
// RULE_03: Read direction bit is never acknowledged.
// RULE_04: Idle waits for START and own address.
// RULE_05: Write is address, command, code bytes.
// RULE_06: Bus command executes at 26th rising edge.
// RULE_07: Aborted bus write leaves outputs unchanged.
// RULE_08: Chip select low shifts data on rising clock.
// RULE_09: Frame: six command then ten code bits.
// RULE_10: Chip select rising executes the shifted command.
// RULE_11: Host keeps chip select low whole frame.
// RULE_12: Writes still accepted while channels shut down.
// RULE_13: Power-up: external reference, lowest range.
// RULE_14: Chain output delays input 16.5 clocks.
// RULE_15: Chain output released while chip select high.
// RULE_16: Host clock at most 10MHz, 5MHz chained.
// RULE_17: Load commands write input and output pairs.
// RULE_18: Input-only loads keep output registers.
// RULE_19: Update commands copy input to output.
// RULE_20: Reference mode commands select internal or external.
// RULE_21: Shutdown and power-up commands per channel.
// RULE_22: Range commands set per-channel full-scale range.
// RULE_23: Interface pin low two-wire, high three-wire.
// RULE_24: STOP anywhere aborts; repeated START restarts.
// RULE_25: Undefined command codes do nothing.
// RULE_26: Codes, shutdown, range and reference exported.
module ddsc_top
    import ddsc_pkg::*;
(
    input  wire logic                mclk,
    input  wire logic                rst,
    input  wire logic                if_select,
    input  wire logic                address_strap_hi,
    input  wire logic                address_strap_lo,
    input  wire logic                scl_in,
    input  wire logic                sda_in,
    output logic                     sda_out,
    output logic                     sda_oe,
    input  wire logic                sclk_in,
    input  wire logic                din_in,
    input  wire logic                cs_n_in,
    output logic                     dout_out,
    output logic                     dout_oe,
    output logic      [CODE_W-1:0]   channel_a_code,
    output logic      [CODE_W-1:0]   channel_b_code,
    output logic                     channel_a_shdn,
    output logic                     channel_b_shdn,
    output logic      [RANGE_W-1:0]  channel_a_range,
    output logic      [RANGE_W-1:0]  channel_b_range,
    output logic                     ref_internal
);

    // ****************************************************************
    // Input synchronisers
    // ****************************************************************
    // Every pin passes two flops; edges compare the second stage with a third flop, prev_reg.
    localparam int NSYNC = 8;
    logic [NSYNC-1:0] sync1_reg;
    logic [NSYNC-1:0] sync2_reg;
    logic [NSYNC-1:0] prev_reg;
    wire  [NSYNC-1:0] pins = {if_select, address_strap_hi, address_strap_lo, scl_in,
                              sda_in, sclk_in, din_in, cs_n_in};

    always_ff @(posedge mclk) begin
        sync1_reg <= pins;
        sync2_reg <= sync1_reg;
        prev_reg  <= sync2_reg;
    end

    wire spi_mode = sync2_reg[7]; // RULE_23
    wire strap_hi = sync2_reg[6];
    wire strap_lo = sync2_reg[5];
    wire scl      = sync2_reg[4];
    wire sda      = sync2_reg[3];
    wire sclk     = sync2_reg[2];
    wire din      = sync2_reg[1];
    wire cs_n     = sync2_reg[0];

    wire scl_rise  = scl & ~prev_reg[4];
    wire scl_fall  = ~scl & prev_reg[4];
    wire sda_fall  = ~sda & prev_reg[3];
    wire sda_rise  = sda & ~prev_reg[3];
    wire sclk_rise = sclk & ~prev_reg[2];
    wire sclk_fall = ~sclk & prev_reg[2];
    wire cs_rise   = cs_n & ~prev_reg[0];

    // ****************************************************************
    // Two-wire slave
    // ****************************************************************
    ddsc_bus_state_t   st_reg;
    logic [4:0]        pulse_reg;
    logic [7:0]        sh_reg;
    logic [7:0]        cmdbyte_reg;
    logic              ack_reg;
    logic              bus_exec_reg;

    wire start_det = ~spi_mode && scl && prev_reg[4] && sda_fall; // RULE_04
    wire stop_det  = ~spi_mode && scl && prev_reg[4] && sda_rise; // RULE_24
    wire [7:0] sh_shift = {sh_reg[6:0], sda};
    wire [6:0] my_addr  = {ADDR_FIXED, strap_hi, strap_lo}; // RULE_02
    wire addr_hit  = (sh_shift[7:1] == my_addr) && ~sh_shift[0]; // RULE_03
    // Pulse numbers count from 1 after START; bytes end at 8, 17, 26.
    wire [4:0] pulse_next = pulse_reg + 5'd1;
    wire byte_end = (pulse_next == 5'd8) || (pulse_next == 5'd17)
                    || (pulse_next == 5'(UPDATE_PULSE));
    wire is_update = (pulse_next == 5'(UPDATE_PULSE));

    always_ff @(posedge mclk) begin
        bus_exec_reg <= 1'b0;
        if (rst || spi_mode) begin
            st_reg      <= BUS_IDLE;
            pulse_reg   <= 5'd0;
            sh_reg      <= 8'h00;
            cmdbyte_reg <= 8'h00;
            ack_reg     <= 1'b0;
        end else if (start_det) begin
            st_reg    <= BUS_RECV; // RULE_24
            pulse_reg <= 5'd0;
            ack_reg   <= 1'b0;
        end else if (stop_det) begin
            st_reg  <= BUS_IDLE; // RULE_07
            ack_reg <= 1'b0;
        end else if (st_reg == BUS_RECV && scl_rise) begin
            sh_reg    <= sh_shift;
            pulse_reg <= pulse_next;
            if (byte_end) begin
                if (pulse_next == 5'd8 && !addr_hit) st_reg <= BUS_IGNORE; // RULE_03
                else st_reg <= BUS_ACK;
                if (pulse_next == 5'd17) cmdbyte_reg <= sh_shift;
                if (is_update) bus_exec_reg <= 1'b1; // RULE_06
            end
        end else if (st_reg == BUS_ACK) begin
            // Drive low from the falling edge before the ninth pulse to the one after it.
            if (scl_fall && !ack_reg) ack_reg <= 1'b1; // RULE_01
            else if (scl_rise) pulse_reg <= pulse_next;
            else if (scl_fall && ack_reg) begin
                ack_reg <= 1'b0;
                st_reg  <= (pulse_reg == 5'(BUS_FRAME_BITS)) ? BUS_IGNORE : BUS_RECV; // RULE_05
            end
        end
    end

    // ****************************************************************
    // Three-wire shift port
    // ****************************************************************
    logic [FRAME_BITS-1:0] spi_sh_reg;
    logic [FRAME_BITS-1:0] chain_reg;
    logic                  spi_exec_reg;
    logic                  dout_reg;
    logic                  tap_reg;

    always_ff @(posedge mclk) begin
        spi_exec_reg <= 1'b0;
        if (rst) begin
            spi_sh_reg <= 16'h0000;
            tap_reg    <= 1'b0;
            dout_reg   <= 1'b0;
        end else if (spi_mode) begin
            if (!cs_n && sclk_rise) spi_sh_reg <= {spi_sh_reg[14:0], din}; // RULE_08
            // The bit pushed out of the register waits half a clock for the falling edge.
            if (!cs_n && sclk_rise) tap_reg <= spi_sh_reg[FRAME_BITS-1]; // RULE_14
            if (!cs_n && sclk_fall) dout_reg <= tap_reg; // RULE_14
            if (cs_rise) spi_exec_reg <= 1'b1; // RULE_10
        end
    end
    assign chain_reg = spi_sh_reg;

    // ****************************************************************
    // Command execution and outputs
    // ****************************************************************
    wire              exec_pulse = bus_exec_reg | spi_exec_reg;
    // Six command bits lead, then ten code bits. RULE_09
    wire [CMD_W-1:0]  exec_cmd   = spi_exec_reg ? chain_reg[15:10] : cmdbyte_reg[7:2];
    wire [CODE_W-1:0] exec_code  = spi_exec_reg ? chain_reg[9:0]
                                                : {cmdbyte_reg[1:0], sh_reg};

    // Undefined codes fall through every decode and change nothing. RULE_25
    ddsc_cmd_exec u_exec (
        .mclk         (mclk),
        .rst          (rst),
        .exec_pulse   (exec_pulse),
        .cmd          (exec_cmd),
        .code         (exec_code),
        .out_code_a   (channel_a_code), // RULE_26
        .out_code_b   (channel_b_code),
        .shdn_a       (channel_a_shdn),
        .shdn_b       (channel_b_shdn),
        .range_a      (channel_a_range),
        .range_b      (channel_b_range),
        .ref_internal (ref_internal)
    );

    // Open drain: the pin is only ever pulled low.
    always_ff @(posedge mclk) begin
        if (rst) begin
            sda_out  <= 1'b0;
            sda_oe   <= 1'b0;
            dout_out <= 1'b0;
            dout_oe  <= 1'b0;
        end else begin
            sda_out  <= 1'b0;
            sda_oe   <= ack_reg && !spi_mode; // RULE_01
            dout_out <= dout_reg;
            dout_oe  <= spi_mode && !cs_n; // RULE_15
        end
    end

endmodule

// [bench/ddsc_monitor.sv]
// Purpose: Port checks of the dual converter command front end.
// Assumes: mclk runs far faster than either bus clock.
// Notes:   Bound to every ddsc_top instance.
module ddsc_monitor
    import ddsc_pkg::*;
(
    input wire logic                mclk,
    input wire logic                rst,
    input wire logic                if_select,
    input wire logic                scl_in,
    input wire logic                sda_out,
    input wire logic                sda_oe,
    input wire logic                cs_n_in,
    input wire logic                dout_oe,
    input wire logic [CODE_W-1:0]   channel_a_code,
    input wire logic [CODE_W-1:0]   channel_b_code,
    input wire logic                channel_a_shdn,
    input wire logic                channel_b_shdn,
    input wire logic [RANGE_W-1:0]  channel_a_range,
    input wire logic [RANGE_W-1:0]  channel_b_range,
    input wire logic                ref_internal
);
    timeunit 1ns;
    timeprecision 1ps;
    wire logic [28:0] st = {channel_a_code, channel_b_code, channel_a_shdn, channel_b_shdn,
                            channel_a_range, channel_b_range, ref_internal};
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    a_ack_pulls_low:
        assert property (sda_oe |-> !sda_out) else $error("ack drives high");
    a_ack_moves_clk_low:
        assert property ($changed(sda_oe) |-> !scl_in) else $error("ack moved in clock high");
    a_ack_two_wire:
        assert property (sda_oe |-> !if_select) else $error("ack in three-wire mode");
    a_chain_three_wire:
        assert property (dout_oe |-> if_select) else $error("chain driven in two-wire mode");
    a_chain_release:
        assert property (cs_n_in [*8] |-> !dout_oe) else $error("chain driven while deselected");
    a_frame_holds_regs:
        assert property ((!cs_n_in && if_select) [*8] |-> $stable(st))
            else $error("outputs moved inside a frame");
    a_bus_low_holds_regs:
        assert property ((!scl_in && !if_select) [*8] |-> $stable(st))
            else $error("outputs moved away from update edge");
    a_power_defaults:
        assert property ($fell(rst) |-> st == {CODE_RESET, CODE_RESET, 2'h0, RANGE_DEFAULT,
                                               RANGE_DEFAULT, REF_EXTERNAL})
            else $error("wrong power-up state");
    a_range_legal:
        assert property (channel_a_range <= RANGE_MAX && channel_b_range <= RANGE_MAX)
            else $error("range out of set");
    a_shdn_keeps_code:
        assert property ($changed({channel_a_shdn, channel_b_shdn}) |-> $stable(st[28:9]))
            else $error("shutdown altered a code");
    c_ack: cover property ($rose(sda_oe));
    c_chain: cover property ($rose(dout_oe));
    c_shdn: cover property ($rose(channel_a_shdn));
endmodule

bind ddsc_top ddsc_monitor i_ddsc_monitor (.mclk(mclk), .rst(rst), .if_select(if_select),
    .scl_in(scl_in), .sda_out(sda_out), .sda_oe(sda_oe), .cs_n_in(cs_n_in), .dout_oe(dout_oe),
    .channel_a_code(channel_a_code), .channel_b_code(channel_b_code),
    .channel_a_shdn(channel_a_shdn), .channel_b_shdn(channel_b_shdn),
    .channel_a_range(channel_a_range), .channel_b_range(channel_b_range),
    .ref_internal(ref_internal));

// [bench/ddsc_host.sv]
// Purpose: Host model driving the two-wire and three-wire command ports.
// Assumes: Tasks are called from one process at a time.
// Notes:   A released data line never keeps its last level.
module ddsc_host (
    input  wire logic  mclk,
    input  wire logic  sda,
    input  wire logic  dout,
    output logic       scl,
    output logic       sda_pull,
    output logic       sclk,
    output logic       din,
    output logic       cs_n
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
        sclk = 1'b0;
        din = 1'b0;
        cs_n = 1'b1;
    end
    task automatic tick(input int n);
        repeat (n) @(negedge mclk);
    endtask
    // Eight mclk per bit gives 5 MHz, safe for a chained run as well.
    task automatic spi(input logic [31:0] w, input int n, output logic [31:0] o);
        o = 32'h0000_0000;
        cs_n = 1'b0;
        tick(4);
        for (int i = n - 1; i >= 0; i--) begin
            din = w[i];
            tick(4);
            sclk = 1'b1;
            tick(4);
            o = {o[30:0], dout};
            sclk = 1'b0;
        end
        tick(4);
        o = {o[30:0], dout};
        cs_n = 1'b1;
        din = ~din;
        tick(20);
    endtask
    task automatic ibit(input logic b, output logic r);
        sda_pull = ~b;
        tick(25);
        scl = 1'b1;
        tick(25);
        r = sda;
        tick(25);
        scl = 1'b0;
        tick(25);
    endtask
    // Ack slots are released so that the device alone decides the level.
    task automatic i2c(input logic [7:0] a, input logic [15:0] d, input int np,
                       input logic rs, output logic [2:0] ak);
        logic [26:0] s;
        logic        r;
        s = {a, 1'b1, d[15:8], 1'b1, d[7:0], 1'b1};
        ak = 3'h0;
        sda_pull = 1'b1;
        tick(25);
        scl = 1'b0;
        tick(25);
        for (int i = 26; i > 26 - np; i--) begin
            ibit(s[i], r);
            if (i % 9 == 0) ak = {ak[1:0], ~r};
        end
        sda_pull = ~rs;
        tick(25);
        scl = 1'b1;
        tick(25);
        sda_pull = 1'b0;
        tick(50);
    endtask
endmodule

// [bench/ddsc_top_test.sv]
// Purpose: Self-checking bench for the dual converter command front end.
// Assumes: The host model owns every bus pin; straps give address 0110010.
// Notes:   Two-wire frames run at 400 kHz and take most of the run.
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin err_count++; \
    $display("BAD %s expected %h seen %h", nm, ex, got); end end
module ddsc_top_test
    import ddsc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic               mclk, rst, if_select, address_strap_hi, address_strap_lo;
    logic               scl, sda_pull, sclk, din, cs_n, sda_out, sda_oe, dout_out, dout_oe;
    logic               channel_a_shdn, channel_b_shdn, ref_internal;
    logic [CODE_W-1:0]  channel_a_code, channel_b_code;
    logic [RANGE_W-1:0] channel_a_range, channel_b_range;
    logic [31:0]        so;
    logic [8:0]         ef;
    logic [2:0]         ak;
    int                 err_count;
    int                 checked;
    wire logic          sda = ~(sda_pull | (sda_oe & ~sda_out));
    localparam logic [5:0] FC [7] = '{CMD_REF_INT, CMD_REF_EXT, CMD_SHDN_AB, CMD_PWUP_A,
                                      CMD_PWUP_B, CMD_SHDN_A, CMD_SHDN_B};
    localparam logic [8:0] FE [7] = '{9'h001, 9'h000, 9'h180, 9'h080, 9'h000, 9'h100, 9'h180};
    ddsc_top i_ddsc_top (.mclk(mclk), .rst(rst), .if_select(if_select),
        .address_strap_hi(address_strap_hi), .address_strap_lo(address_strap_lo),
        .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .sclk_in(sclk),
        .din_in(din), .cs_n_in(cs_n), .dout_out(dout_out), .dout_oe(dout_oe),
        .channel_a_code(channel_a_code), .channel_b_code(channel_b_code),
        .channel_a_shdn(channel_a_shdn), .channel_b_shdn(channel_b_shdn),
        .channel_a_range(channel_a_range), .channel_b_range(channel_b_range),
        .ref_internal(ref_internal));
    ddsc_host i_ddsc_host (.mclk(mclk), .sda(sda), .dout(dout_out), .scl(scl),
        .sda_pull(sda_pull), .sclk(sclk), .din(din), .cs_n(cs_n));
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    task automatic cst(input logic [9:0] ea, input logic [9:0] eb);
        `CHK("state", {ea, eb, ef}, {channel_a_code, channel_b_code, channel_a_shdn,
             channel_b_shdn, channel_a_range, channel_b_range, ref_internal})
    endtask
    // One command through whichever port the mode pin selects.
    task automatic go(input logic [5:0] c, input logic [9:0] d, input logic [9:0] ea,
                      input logic [9:0] eb);
        if (if_select === 1'b1) begin
            i_ddsc_host.spi({16'h0000, c, d}, 16, so);
        end else begin
            i_ddsc_host.i2c(8'h64, {c, d}, 27, 1'b0, ak);
            `CHK("acks", 3'h7, ak)
        end
        cst(ea, eb);
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        repeat (60000) @(posedge mclk);
        err_count++;
        test_done();
    end
    initial begin
        rst = 1'b1;
        if_select = 1'b1;
        address_strap_hi = 1'b1;
        address_strap_lo = 1'b0;
        ef = 9'h000;
        err_count = 0;
        checked = 0;
        repeat (20) @(negedge mclk);
        rst = 1'b0;
        repeat (4) @(negedge mclk);
        cst(CODE_RESET, CODE_RESET);
        go(CMD_LOAD_AB, 10'h2A5, 10'h2A5, 10'h2A5);
        go(CMD_LOAD_A, 10'h155, 10'h155, 10'h2A5);
        go(CMD_LOAD_B, 10'h0F0, 10'h155, 10'h0F0);
        go(CMD_IN_AB, 10'h3FF, 10'h155, 10'h0F0);
        go(CMD_UPD_A, 10'h0AA, 10'h3FF, 10'h0F0);
        go(CMD_IN_B, 10'h001, 10'h3FF, 10'h0F0);
        go(CMD_IN_A, 10'h200, 10'h3FF, 10'h0F0);
        go(CMD_UPD_B, 10'h3FF, 10'h3FF, 10'h001);
        go(CMD_UPD_AB, 10'h0AA, 10'h200, 10'h001);
        go(CMD_NOP, 10'h3FF, 10'h200, 10'h001);
        go(6'h08, 10'h3FF, 10'h200, 10'h001);
        for (int i = 0; i < 7; i++) begin
            ef = FE[i];
            go(FC[i], 10'h3FF, 10'h200, 10'h001);
        end
        go(CMD_LOAD_AB, 10'h123, 10'h123, 10'h123);
        ef = 9'h000;
        go(CMD_PWUP_AB, 10'h3FF, 10'h123, 10'h123);
        for (int i = 0; i < 6; i++) begin
            ef = {2'h0, 3'(i), 3'h0, 1'h0};
            go({RANGE_GRP_A, 3'(i)}, 10'h3FF, 10'h123, 10'h123);
        end
        for (int i = 0; i < 6; i++) begin
            ef = {2'h0, 3'h5, 3'(i), 1'h0};
            go({RANGE_GRP_B, 3'(i)}, 10'h3FF, 10'h123, 10'h123);
        end
        go(6'h16, 10'h3FF, 10'h123, 10'h123);
        $display("test three_wire done");
        i_ddsc_host.spi(32'hA5C3_0000, 32, so);
        `CHK("chain", 16'hA5C3, so[15:0])
        cst(10'h123, 10'h123);
        $display("test chain done");
        if_select = 1'b0;
        repeat (8) @(negedge mclk);
        i_ddsc_host.spi({16'h0000, CMD_LOAD_AB, 10'h3FF}, 16, so);
        cst(10'h123, 10'h123);
        go(CMD_LOAD_A, 10'h0C3, 10'h0C3, 10'h123);
        i_ddsc_host.i2c(8'h64, {CMD_LOAD_B, 10'h3C0}, 27, 1'b1, ak);
        go(CMD_IN_A, 10'h3FF, 10'h0C3, 10'h3C0);
        i_ddsc_host.i2c(8'h66, {CMD_LOAD_AB, 10'h000}, 27, 1'b0, ak);
        `CHK("foreign address", 3'h0, ak)
        i_ddsc_host.i2c(8'h65, {CMD_LOAD_AB, 10'h000}, 9, 1'b0, ak);
        `CHK("read", 3'h0, ak)
        i_ddsc_host.i2c(8'h64, {CMD_LOAD_AB, 10'h000}, 24, 1'b0, ak);
        `CHK("abort acks", 3'h3, ak)
        cst(10'h0C3, 10'h3C0);
        go(CMD_UPD_A, 10'h000, 10'h3FF, 10'h3C0);
        $display("test two_wire done");
        test_done();
    end
endmodule
